// ==== pkg/qsfd_pkg.sv ====
// Constants and types shared by the quad switch fault diagnostics block
package qsfd_pkg;
	localparam int unsigned QSFD_NCH = 4;
	localparam int unsigned QSFD_NCAUSE = 4;
	localparam int unsigned QSFD_AW = 8;
	// Register byte addresses
	localparam logic [QSFD_AW-1:0] QSFD_ADDR_CTRL = 8'h00;
	localparam logic [QSFD_AW-1:0] QSFD_ADDR_STATUS = 8'h04;
	localparam logic [QSFD_AW-1:0] QSFD_ADDR_EVENTS = 8'h08;
	localparam logic [QSFD_AW-1:0] QSFD_ADDR_PINS = 8'h0C;
	// CTRL fields
	localparam int unsigned QSFD_CTRL_VARB_BIT = 0;
	localparam logic QSFD_CTRL_VARB_RST = 1'b0;
	// STATUS field positions, four bits each
	localparam int unsigned QSFD_ST_FAULT_POS = 0;
	localparam int unsigned QSFD_ST_GATE_POS = 4;
	localparam int unsigned QSFD_ST_LIMIT_POS = 8;
	localparam int unsigned QSFD_ST_DRIVE_POS = 12;
	// Cause bit positions inside each channel nibble
	localparam int unsigned QSFD_C_OC = 0;
	localparam int unsigned QSFD_C_OL = 1;
	localparam int unsigned QSFD_C_TSD = 2;
	localparam int unsigned QSFD_C_SW = 3;
	localparam logic [15:0] QSFD_EVENTS_RST = 16'h0000;
	localparam logic [31:0] QSFD_RDATA_RST = 32'h00000000;
	// Thermal shutdown handling, Gray along ok, shut, retry
	typedef enum logic [1:0] {
		QSFD_TS_OK = 2'b00,
		QSFD_TS_SHUT = 2'b01,
		QSFD_TS_RETRY = 2'b11,
		QSFD_TS_LATCH = 2'b10
	} qsfd_ts_t;
	// Level requested from the shared sense output
	typedef enum logic [1:0] {
		QSFD_CS_ZERO = 2'b00,
		QSFD_CS_LINEAR = 2'b01,
		QSFD_CS_HIGH = 2'b11
	} qsfd_cs_t;
endpackage

// ==== pkg/qsfd_chan_if.sv ====
// Carrier between the top and one channel fault engine
`timescale 1ns/1ps
interface qsfd_chan_if;
	logic drive;
	logic diag_on;
	logic latch_sel;
	logic oc_hit;
	logic ol_hit;
	logic tsd_hot;
	logic tsd_cool;
	logic tsd_rst;
	logic sw_hot;
	logic sw_cool;
	logic gate_on;
	logic reduced_limit;
	logic fault;
	logic [3:0] cause;
	modport engine(input drive, input diag_on, input latch_sel, input oc_hit, input ol_hit,
		input tsd_hot, input tsd_cool, input tsd_rst, input sw_hot, input sw_cool,
		output gate_on, output reduced_limit, output fault, output cause);
	modport top(output drive, output diag_on, output latch_sel, output oc_hit, output ol_hit,
		output tsd_hot, output tsd_cool, output tsd_rst, output sw_hot, output sw_cool,
		input gate_on, input reduced_limit, input fault, input cause);
endinterface

// ==== hw/qsfd_chan_engine.sv ====
// Per-channel protection and fault state of the quad switch
`timescale 1ns/1ps
module qsfd_chan_engine
	import qsfd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	qsfd_chan_if.engine ch
);
	typedef struct packed {
		qsfd_ts_t ts;
		logic drive_prev;
		logic tsd_flag;
		logic sw_off;
		logic gate_on;
		logic reduced;
		logic fault;
		logic [3:0] cause;
	} qsfd_chan_st_t;

	qsfd_chan_st_t st_ff;
	qsfd_chan_st_t nxt_st;

	always_comb begin
		logic toggle;
		logic oc_f;
		logic ol_f;
		logic tsd_enter;
		logic tsd_clr;
		logic thermal_off;
		toggle = ch.drive ^ st_ff.drive_prev;
		oc_f = ch.drive & ch.oc_hit; // [R06]
		// Off-state comparator covers open load, battery short, reverse polarity
		ol_f = ~ch.drive & ch.ol_hit; // [R07] [R10] [R11]
		// No on-state open-load input: only the sense reading shows it [R08]
		tsd_enter = ch.drive & ch.tsd_hot; // [R12]
		nxt_st = st_ff;
		nxt_st.drive_prev = ch.drive;
		unique case (st_ff.ts)
			QSFD_TS_OK: begin
				if (tsd_enter) begin
					nxt_st.ts = ch.latch_sel ? QSFD_TS_LATCH : QSFD_TS_SHUT; // [R12] [R14]
				end
			end
			QSFD_TS_SHUT: begin
				if (ch.tsd_cool) begin
					nxt_st.ts = QSFD_TS_RETRY; // [R13]
				end
			end
			QSFD_TS_RETRY: begin
				if (tsd_enter) begin
					nxt_st.ts = ch.latch_sel ? QSFD_TS_LATCH : QSFD_TS_SHUT;
				end else if (ch.tsd_rst) begin
					nxt_st.ts = QSFD_TS_OK;
				end
			end
			QSFD_TS_LATCH: begin
				if (!ch.latch_sel) begin
					nxt_st.ts = QSFD_TS_SHUT; // [R15]
				end else if (toggle) begin
					// Toggle onto a still-hot die re-latches at once
					nxt_st.ts = tsd_enter ? QSFD_TS_LATCH : QSFD_TS_OK; // [R12] [R14]
				end
			end
		endcase
		// Latched flag only yields to a drive toggle; set wins over clear
		tsd_clr = toggle | (ch.tsd_rst & (st_ff.ts != QSFD_TS_LATCH)); // [R13] [R14]
		// A toggle while still hot raises the flag again, so the fault is not lost
		nxt_st.tsd_flag = (tsd_enter & (toggle | (st_ff.ts == QSFD_TS_OK) | (st_ff.ts == QSFD_TS_RETRY)))
			| (st_ff.tsd_flag & ~tsd_clr);
		// Swing works whatever the latch choice
		if (ch.drive & ch.sw_hot) begin
			nxt_st.sw_off = 1'b1; // [R16]
		end else if (ch.sw_cool) begin
			nxt_st.sw_off = 1'b0; // [R17]
		end
		thermal_off = (nxt_st.ts == QSFD_TS_SHUT) | (nxt_st.ts == QSFD_TS_LATCH);
		// Protection acts on the gate whether or not diagnostics run
		nxt_st.gate_on = ch.drive & ~thermal_off & ~nxt_st.sw_off; // [R02] [R12]
		nxt_st.reduced = nxt_st.ts == QSFD_TS_RETRY; // [R13]
		nxt_st.cause[QSFD_C_OC] = oc_f;
		nxt_st.cause[QSFD_C_OL] = ol_f;
		nxt_st.cause[QSFD_C_TSD] = nxt_st.tsd_flag;
		nxt_st.cause[QSFD_C_SW] = nxt_st.sw_off;
		nxt_st.fault = ch.diag_on & (|nxt_st.cause); // [R05]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{ts: QSFD_TS_OK, drive_prev: 1'b0, tsd_flag: 1'b0, sw_off: 1'b0,
				gate_on: 1'b0, reduced: 1'b0, fault: 1'b0, cause: 4'h0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign ch.gate_on = st_ff.gate_on;
	assign ch.reduced_limit = st_ff.reduced;
	assign ch.fault = st_ff.fault;
	assign ch.cause = st_ff.cause;
endmodule

// ==== hw/qsfd_top.sv ====
// Fault diagnostics and reporting for a four-channel high-side switch
//
// What this block does
// R01 - Gate low: diagnostics off, sense and all fault flags left undriven.
// R02 - Gate low: driven channels keep protection, undriven channels have none.
// R03 - Sense picks 00, 01, 11 route sense to channels 1, 2, 4.
// R04 - Sense picks high 1, low 0 route sense to channel 3.
// R05 - Fault reporting only with gate high; normal sense zero off, linear on.
// R06 - Driven channel over current limit reports fault, clears automatically.
// R07 - Undriven channel with output near supply reports fault, clears automatically.
// R08 - Open load while driven raises no flag, only a near-zero sense.
// R09 - Host steps sense picks to find on-state open loads.
// R10 - Short to battery reported like open load.
// R11 - Reverse polarity reported like open load.
// R12 - Each channel over shutdown temperature turns itself off, reports fault.
// R13 - Latch choice low: retry after cooling, reduced limit, flag clears later.
// R14 - Latch choice high: stays off, flag clears on drive toggle.
// R15 - Latch choice falling turns latch handling into auto-retry.
// R16 - Thermal swing turns output off and reports fault, any latch choice.
// R17 - Swing cleared below threshold minus hysteresis: output back, fault cleared.
// R18 - Flag variant: per-channel open-drain flag pulled low while faulted.
// R19 - Sense variant: global open-drain flag pulled low on any fault.
// R20 - Selected channel faulted: sense driven to its high fault level.
// R21 - After global flag the host scans sense picks for the culprit.
// R22 - Host may idle gate and drives low, gate one device at a time.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module qsfd_top
	import qsfd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [QSFD_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic diagnostics_gate,
	input wire logic [QSFD_NCH-1:0] channel_drive_input,
	input wire logic sense_pick_high_bit,
	input wire logic sense_pick_low_bit,
	input wire logic overheat_latch_choice,
	input wire logic [QSFD_NCH-1:0] overcurrent_hit,
	input wire logic [QSFD_NCH-1:0] off_open_hit,
	input wire logic [QSFD_NCH-1:0] shutdown_hot,
	input wire logic [QSFD_NCH-1:0] shutdown_cooled,
	input wire logic [QSFD_NCH-1:0] shutdown_reset_temp,
	input wire logic [QSFD_NCH-1:0] swing_hot,
	input wire logic [QSFD_NCH-1:0] swing_cooled,
	output logic [QSFD_NCH-1:0] switch_terminal_on,
	output logic [QSFD_NCH-1:0] protection_active,
	output logic [QSFD_NCH-1:0] reduced_limit,
	output logic [1:0] sense_route,
	output qsfd_cs_t sense_level,
	output logic sense_oe,
	output logic [QSFD_NCH-1:0] channel_fault_flag_n_o,
	output logic [QSFD_NCH-1:0] channel_fault_flag_n_oe,
	output logic global_fault_n_o,
	output logic global_fault_n_oe
);
	typedef struct packed {
		logic varb;
		logic [15:0] events;
		logic [31:0] rdata;
		logic slverr;
		logic [QSFD_NCH-1:0] protect;
		logic [1:0] route;
		qsfd_cs_t cs;
		logic cs_oe;
		logic [QSFD_NCH-1:0] flag_oe;
		logic glob_oe;
	} qsfd_top_st_t;

	qsfd_top_st_t st_ff;
	qsfd_top_st_t nxt_st;

	logic [QSFD_NCH-1:0] ch_gate;
	logic [QSFD_NCH-1:0] ch_limit;
	logic [QSFD_NCH-1:0] ch_fault;
	logic [15:0] ch_cause;

	// Address decode, used only for the error answer; the read path decodes paddr in its own case
	function automatic logic qsfd_mapped(input logic [QSFD_AW-1:0] a);
		return (a == QSFD_ADDR_CTRL) || (a == QSFD_ADDR_STATUS) ||
			(a == QSFD_ADDR_EVENTS) || (a == QSFD_ADDR_PINS);
	endfunction

	// Channel number picked by the two sense pins
	function automatic logic [1:0] qsfd_pick(input logic hi, input logic lo);
		return {hi, lo}; // [R03] [R04]
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < QSFD_NCH; gi++) begin : g_ch
			qsfd_chan_if chif();
			assign chif.drive = channel_drive_input[gi];
			assign chif.diag_on = diagnostics_gate;
			assign chif.latch_sel = overheat_latch_choice;
			assign chif.oc_hit = overcurrent_hit[gi];
			assign chif.ol_hit = off_open_hit[gi];
			assign chif.tsd_hot = shutdown_hot[gi];
			assign chif.tsd_cool = shutdown_cooled[gi];
			assign chif.tsd_rst = shutdown_reset_temp[gi];
			assign chif.sw_hot = swing_hot[gi];
			assign chif.sw_cool = swing_cooled[gi];
			assign ch_gate[gi] = chif.gate_on;
			assign ch_limit[gi] = chif.reduced_limit;
			assign ch_fault[gi] = chif.fault;
			assign ch_cause[gi*4 +: 4] = chif.cause;
			qsfd_chan_engine u_eng (
				.pclk(pclk),
				.presetn(presetn),
				.ch(chif.engine)
			);
		end
	endgenerate

	always_comb begin
		logic setup;
		logic wr;
		logic [1:0] pick;
		logic [31:0] rd;
		logic [15:0] clr;
		setup = psel & ~penable;
		wr = psel & penable & pwrite;
		pick = qsfd_pick(sense_pick_high_bit, sense_pick_low_bit);
		rd = QSFD_RDATA_RST;
		clr = 16'h0000;
		nxt_st = st_ff;

		// Read data and error are fixed in the setup cycle so they leave flops
		if (setup) begin
			unique case (paddr)
				QSFD_ADDR_CTRL: begin
					rd[QSFD_CTRL_VARB_BIT] = st_ff.varb;
				end
				QSFD_ADDR_STATUS: begin
					rd[QSFD_ST_FAULT_POS +: 4] = ch_fault;
					rd[QSFD_ST_GATE_POS +: 4] = ch_gate;
					rd[QSFD_ST_LIMIT_POS +: 4] = ch_limit;
					rd[QSFD_ST_DRIVE_POS +: 4] = channel_drive_input;
				end
				QSFD_ADDR_EVENTS: begin
					rd[15:0] = st_ff.events;
				end
				QSFD_ADDR_PINS: begin
					rd[0] = diagnostics_gate;
					rd[1] = sense_pick_low_bit;
					rd[2] = sense_pick_high_bit;
					rd[3] = overheat_latch_choice;
				end
				default: begin
					rd = QSFD_RDATA_RST;
				end
			endcase
			nxt_st.rdata = rd;
			nxt_st.slverr = ~qsfd_mapped(paddr);
		end

		if (wr && paddr == QSFD_ADDR_CTRL && pstrb[0]) begin
			nxt_st.varb = pwdata[QSFD_CTRL_VARB_BIT];
		end
		if (wr && paddr == QSFD_ADDR_EVENTS) begin
			clr[7:0] = pstrb[0] ? pwdata[7:0] : 8'h00;
			clr[15:8] = pstrb[1] ? pwdata[15:8] : 8'h00;
		end
		// Sticky cause history; a new cause beats a clear in the same cycle
		nxt_st.events = ch_cause | (st_ff.events & ~clr);

		// Driven channel keeps its protection even with diagnostics gated off
		nxt_st.protect = channel_drive_input; // [R02]

		// Shared sense path
		nxt_st.route = pick; // [R03] [R04]
		if (!diagnostics_gate) begin
			nxt_st.cs = QSFD_CS_ZERO; // [R01]
		end else if (ch_fault[pick]) begin
			nxt_st.cs = QSFD_CS_HIGH; // [R20]
		end else if (ch_gate[pick]) begin
			nxt_st.cs = QSFD_CS_LINEAR; // [R05]
		end else begin
			nxt_st.cs = QSFD_CS_ZERO; // [R05]
		end
		// Sense pin only exists in the sense variant; gate low leaves it floating
		nxt_st.cs_oe = diagnostics_gate & st_ff.varb; // [R01]

		// Open-drain flags: enable means pulled to ground
		nxt_st.flag_oe = {QSFD_NCH{diagnostics_gate & ~st_ff.varb}} & ch_fault; // [R18] [R01]
		nxt_st.glob_oe = diagnostics_gate & st_ff.varb & (|ch_fault); // [R19] [R01]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{varb: QSFD_CTRL_VARB_RST, events: QSFD_EVENTS_RST, rdata: QSFD_RDATA_RST,
				slverr: 1'b0, protect: '0, route: 2'b00, cs: QSFD_CS_ZERO, cs_oe: 1'b0,
				flag_oe: '0, glob_oe: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Zero-wait slave: access phase always completes in one cycle
	assign pready = 1'b1;
	assign prdata = st_ff.rdata;
	assign pslverr = st_ff.slverr;

	assign switch_terminal_on = ch_gate;
	assign reduced_limit = ch_limit;
	assign protection_active = st_ff.protect;
	assign sense_route = st_ff.route;
	assign sense_level = st_ff.cs;
	assign sense_oe = st_ff.cs_oe;
	// Open drain never drives high
	assign channel_fault_flag_n_o = '0;
	assign channel_fault_flag_n_oe = st_ff.flag_oe;
	assign global_fault_n_o = 1'b0;
	assign global_fault_n_oe = st_ff.glob_oe;
endmodule

// ==== verif/qsfd_host_pullups.sv ====
// Host-side pull-ups on the open-drain fault lines
`timescale 1ns/1ps
module qsfd_host_pullups (
	input wire logic [3:0] ch_o,
	input wire logic [3:0] ch_oe,
	input wire logic gl_o,
	input wire logic gl_oe,
	output logic [3:0] ch_lvl_n,
	output logic gl_lvl_n
);
	// Released line rises to the pull-up, never keeps its last level
	assign ch_lvl_n = (ch_oe & ch_o) | ~ch_oe;
	assign gl_lvl_n = gl_oe ? gl_o : 1'b1;
endmodule

// ==== verif/qsfd_top_checker.sv ====
// Port assertions for the quad switch fault block
`timescale 1ns/1ps
module qsfd_top_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic diagnostics_gate,
	input wire logic [3:0] channel_drive_input,
	input wire logic sense_pick_high_bit,
	input wire logic sense_pick_low_bit,
	input wire logic overheat_latch_choice,
	input wire logic [3:0] overcurrent_hit,
	input wire logic [3:0] shutdown_hot,
	input wire logic [3:0] swing_hot,
	input wire logic [3:0] switch_terminal_on,
	input wire logic [3:0] protection_active,
	input wire logic [1:0] sense_route,
	input wire logic sense_oe,
	input wire logic [3:0] channel_fault_flag_n_o,
	input wire logic [3:0] channel_fault_flag_n_oe,
	input wire logic global_fault_n_o,
	input wire logic global_fault_n_oe
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_gate_off_quiet: assert property ($past(presetn, 2) && !$past(diagnostics_gate) && !$past(diagnostics_gate, 2)
		|-> !sense_oe && !global_fault_n_oe && !channel_fault_flag_n_oe) else $error("fault pins driven, gate off");
	a_route_follows: assert property ($past(presetn) |->
		sense_route == $past({sense_pick_high_bit, sense_pick_low_bit})) else $error("sense route wrong");
	a_prot_follows: assert property ($past(presetn) |-> protection_active == $past(channel_drive_input))
		else $error("protection does not follow drive");
	a_drain_low: assert property (channel_fault_flag_n_o == 4'h0 && !global_fault_n_o
		&& !(global_fault_n_oe && (|channel_fault_flag_n_oe))) else $error("open drain pulls high or both variants drive");
	a_oc_flagged: assert property ((diagnostics_gate && channel_drive_input[0] && overcurrent_hit[0]) [*3]
		|-> channel_fault_flag_n_oe[0] || global_fault_n_oe) else $error("overcurrent not flagged");
	a_tsd_off: assert property (channel_drive_input[0] && shutdown_hot[0] |=> !switch_terminal_on[0])
		else $error("hot channel still on");
	a_swing_off: assert property (channel_drive_input[0] && swing_hot[0] |=> !switch_terminal_on[0])
		else $error("swinging channel still on");
	a_latch_holds: assert property (overheat_latch_choice && channel_drive_input[0] && shutdown_hot[0] ##1
		(overheat_latch_choice && channel_drive_input[0]) [*3] |-> !switch_terminal_on[0]) else $error("latch let go");
endmodule
bind qsfd_top qsfd_top_checker u_chk (.*);

// ==== verif/qsfd_top_tb.sv ====
// Self-checking bench for the quad switch fault block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch t=%0t got %h want %h", $time, a, b); end end
module qsfd_top_tb
	import qsfd_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gt, ph, pl, lat, soe, go, goe, flt_n, er;
	logic [1:0] rte;
	logic [3:0] pstrb, dr, oc, ol, hot, cool, rtmp, swh, swc, son, prot, rlim, fo, foe, st_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	qsfd_cs_t slv;
	int err_count, n_compared;
	// {gate, latch, picks}, drive, oc, hot, cooled, reset temp, swing hot, swing cooled; then expected outputs
	logic [43:0] rows [16] = '{
		44'h8D800000_9F1,
		44'h9D800000_9F0,
		44'hAD800000_9F1,
		44'hBD800000_9F3,
		44'h8D010000_1F3,
		44'h8D001000_DF3,
		44'h8D000100_BF1,
		44'hCD010000_1F3,
		44'hCD001000_1F3,
		44'h8D001000_DF3,
		44'hCD010000_1F3,
		44'hCC000000_3F0,
		44'hCD000000_BF1,
		44'hCD000010_1F3,
		44'hCD000001_BF1,
		44'h4D000000_AF0
	};
	qsfd_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.diagnostics_gate(gt), .channel_drive_input(dr), .sense_pick_high_bit(ph), .sense_pick_low_bit(pl),
		.overheat_latch_choice(lat), .overcurrent_hit(oc), .off_open_hit(ol), .shutdown_hot(hot),
		.shutdown_cooled(cool), .shutdown_reset_temp(rtmp), .swing_hot(swh), .swing_cooled(swc),
		.switch_terminal_on(son), .protection_active(prot), .reduced_limit(rlim), .sense_route(rte),
		.sense_level(slv), .sense_oe(soe), .channel_fault_flag_n_o(fo), .channel_fault_flag_n_oe(foe),
		.global_fault_n_o(go), .global_fault_n_oe(goe));
	qsfd_host_pullups u_host (.ch_o(fo), .ch_oe(foe), .gl_o(go), .gl_oe(goe), .ch_lvl_n(st_n), .gl_lvl_n(flt_n));
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			err_count++;
			complete_run();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Outputs are read mid-cycle, after the edge's updates have landed
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		complete_run();
	end
	initial begin
		// Host starts with gate and drives low; the drives rise before the gate does
		{presetn, psel, penable, pwrite, gt, ph, pl, lat, paddr, pwdata} = '0;
		{dr, oc, ol, hot, cool, rtmp, swh, swc} = '0;
		pstrb = 4'hF;
		err_count = 0;
		n_compared = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, QSFD_ADDR_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, 8'h40, 32'h0);
		`CHK(er, 1'b1)
		@(posedge pclk);
		dr <= 4'h5;
		oc <= 4'h1;
		wt(3);
		`CHK({foe, goe, soe, st_n, prot}, 14'h00F5)
		@(posedge pclk);
		gt <= 1'b1;
		ol <= 4'h6;
		wt(3);
		`CHK(st_n, 4'hC)
		@(posedge pclk);
		{oc, ol} <= 8'h00;
		wt(3);
		`CHK(st_n, 4'hF)
		apb(1'b1, QSFD_ADDR_CTRL, 32'h1);
		apb(1'b0, QSFD_ADDR_CTRL, 32'h0);
		`CHK(rd, 32'h1)
		// Rows 0-3 step the picks to locate the faulted channel; later rows cover shutdown, latch, swing and gate off
		foreach (rows[k]) begin
			@(posedge pclk);
			{gt, lat, ph, pl, dr, oc, hot, cool, rtmp, swh, swc} <= rows[k][43:12];
			wt(3);
			`CHK({son[0], rlim[0], flt_n, soe, st_n, 2'b00, slv}, rows[k][11:0])
			`CHK(rte, {ph, pl})
		end
		apb(1'b0, QSFD_ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h0000D0D0)
		// Sticky causes: ch0 overcurrent, shutdown, swing; ch1 open; ch3 overcurrent
		apb(1'b0, QSFD_ADDR_EVENTS, 32'h0);
		`CHK(rd, 32'h0000102D)
		apb(1'b1, QSFD_ADDR_EVENTS, 32'h0000000D);
		apb(1'b0, QSFD_ADDR_EVENTS, 32'h0);
		`CHK(rd, 32'h00001020)
		apb(1'b0, QSFD_ADDR_PINS, 32'h0);
		`CHK(rd, 32'h00000008)
		// Reset in mid-run: state back to idle, channels return from their inputs
		@(posedge pclk);
		presetn <= 1'b0;
		wt(2);
		`CHK({son, prot, rlim, rte}, 14'h0000)
		@(posedge pclk);
		presetn <= 1'b1;
		wt(2);
		`CHK({son, prot}, 8'hDD)
		apb(1'b0, QSFD_ADDR_EVENTS, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, QSFD_ADDR_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		complete_run();
	end
endmodule
